//--- src/pioc_top.v
// AHB-Lite register bank for port interrupts and operation control, ports 1-7
//
// The AHB-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`include "pioc_defs.vh"
module pioc_top #(
  parameter [6:0] PHY_PORTS = 7'h1f   // Ports 1-5 have a transceiver
) (
  input  wire        clock_i,          // 40 MHz system clock
  input  wire        resetn_i,         // Async reset, active low
  input  wire        hsel_i,           // AHB slave select
  input  wire [31:0] haddr_i,          // AHB address
  input  wire [1:0]  htrans_i,         // AHB transfer type
  input  wire        hwrite_i,         // AHB write
  input  wire [2:0]  hsize_i,          // AHB size
  input  wire [31:0] hwdata_i,         // AHB write data
  input  wire        hready_i,         // AHB bus ready
  output reg  [31:0] hrdata_o,         // AHB read data
  output reg         hreadyout_o,      // AHB slave ready
  output reg         hresp_o,          // AHB response, always OKAY
  input  wire [6:0]  an_done_i,        // Per-port SGMII AN done, pin domain
  input  wire [6:0]  phy_irq_i,        // Per-port PHY summary, pin domain
  input  wire [6:0]  acl_irq_i,        // Per-port ACL event pulse, same clock
  output reg  [6:0]  irq_o,            // Per-port interrupt request
  output reg  [6:0]  local_loop_o,     // Per-port fabric-side loopback
  output reg  [6:0]  remote_loop_o,    // Per-port pin-side loopback
  output reg  [6:0]  tail_tag_o,       // Per-port tail tag / host port
  output reg  [13:0] queue_mode_o,     // Per-port queue split, 2 bits each
  output reg  [6:0]  prio_en_o         // Per-port priority queueing on
);
  // Address phase capture
  reg         wr_pend_r;
  reg         rd_pend_r;
  reg  [2:0]  port_r;
  reg  [11:0] off_r;
  wire        access;
  wire [3:0]  port_num;
  wire        port_ok;
  // Pin synchronisers, three stages, change once stages two and three agree
  reg  [6:0]  an_s1_r, an_s2_r, an_s3_r, an_r;
  reg  [6:0]  phy_s1_r, phy_s2_r, phy_s3_r, phy_r;
  // Per-port register outputs
  wire [7:0]  flags_w [0:6];
  wire [7:0]  mask_w  [0:6];
  wire [7:0]  ctrl_w  [0:6];
  wire [6:0]  irq_w;
  reg  [31:0] rdata_nxt;
  integer     k;

  assign access   = hsel_i & hready_i & htrans_i[1];
  // Registers are word-indexed: byte address is four times the index
  assign port_num = haddr_i[17:14];
  assign port_ok  = (port_num >= 4'h1) & (port_num <= 4'h7) &
                    (haddr_i[31:18] == 14'h0000) &
                    (haddr_i[1:0] == 2'h0);

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_pend_r   <= 1'b0;
      rd_pend_r   <= 1'b0;
      port_r      <= 3'h0;
      off_r       <= 12'h000;
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end else begin
      wr_pend_r <= access & hwrite_i & port_ok;
      rd_pend_r <= access & ~hwrite_i;
      if (access) begin
        port_r <= port_ok ? (port_num[2:0] - 3'h1) : 3'h0;
        off_r  <= port_ok ? haddr_i[13:2] : 12'hfff;
      end
      hreadyout_o <= 1'b1;
      hresp_o     <= 1'b0;
    end
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      an_s1_r  <= 7'h00;
      an_s2_r  <= 7'h00;
      an_s3_r  <= 7'h00;
      an_r     <= 7'h00;
      phy_s1_r <= 7'h00;
      phy_s2_r <= 7'h00;
      phy_s3_r <= 7'h00;
      phy_r    <= 7'h00;
    end else begin
      an_s1_r  <= an_done_i;
      an_s2_r  <= an_s1_r;
      an_s3_r  <= an_s2_r;
      an_r     <= (an_s2_r & an_s3_r) | (an_r & (an_s2_r | an_s3_r));
      phy_s1_r <= phy_irq_i;
      phy_s2_r <= phy_s1_r;
      phy_s3_r <= phy_s2_r;
      phy_r    <= (phy_s2_r & phy_s3_r) | (phy_r & (phy_s2_r | phy_s3_r));
    end
  end

  genvar g;
  generate
    for (g = 0; g < `PIOC_NPORTS; g = g + 1) begin : g_port
      wire sel_w;
      assign sel_w = wr_pend_r & (port_r == g);
      pioc_port_regs #(
        .HAS_PHY (PHY_PORTS[g])
      ) u_regs (
        .clock_i   (clock_i),
        .resetn_i  (resetn_i),
        .an_done_i (an_r[g]),
        .phy_irq_i (phy_r[g]),
        .acl_irq_i (acl_irq_i[g]),
        .mask_we_i (sel_w & (off_r == `PIOC_OFF_MASK)),
        .ctrl_we_i (sel_w & (off_r == `PIOC_OFF_CTRL)),
        .wdata_i   (hwdata_i[7:0]),
        .flags_o   (flags_w[g]),
        .mask_o    (mask_w[g]),
        .ctrl_o    (ctrl_w[g]),
        .irq_o     (irq_w[g])
      );
    end
  endgenerate

  // Read data is muxed in the data phase so it reflects current state
  always @* begin
    rdata_nxt = 32'h00000000;
    case (off_r)
      `PIOC_OFF_FLAGS: rdata_nxt = {24'h000000, flags_w[port_r]};
      `PIOC_OFF_MASK:  rdata_nxt = {24'h000000, mask_w[port_r]};
      `PIOC_OFF_CTRL:  rdata_nxt = {24'h000000, ctrl_w[port_r]};
      default:         rdata_nxt = 32'h00000000;
    endcase
    if (!rd_pend_r) begin
      rdata_nxt = 32'h00000000;
    end
  end

  always @* begin
    hrdata_o = rdata_nxt;
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      irq_o         <= 7'h00;
      local_loop_o  <= 7'h00;
      remote_loop_o <= 7'h00;
      tail_tag_o    <= 7'h00;
      queue_mode_o  <= 14'h0000;
      prio_en_o     <= 7'h00;
    end else begin
      irq_o <= irq_w;
      for (k = 0; k < `PIOC_NPORTS; k = k + 1) begin
        local_loop_o[k]  <= ctrl_w[k][`PIOC_BIT_LLOOP];
        remote_loop_o[k] <= ctrl_w[k][`PIOC_BIT_RLOOP];
        tail_tag_o[k]    <= ctrl_w[k][`PIOC_BIT_TTAG];
        queue_mode_o[2*k +: 2] <= ctrl_w[k][1:0];
        prio_en_o[k] <= (ctrl_w[k][1:0] == `PIOC_Q_TWO) |
                        (ctrl_w[k][1:0] == `PIOC_Q_FOUR);
      end
    end
  end
endmodule // pioc_top

//--- src/pioc_defs.vh
// Register offsets, field positions, reset values and encodings
`ifndef PIOC_DEFS_VH
`define PIOC_DEFS_VH
`define PIOC_ADDR_W        16
`define PIOC_PORT_STRIDE   16'h1000
`define PIOC_OFF_FLAGS     12'h01b
`define PIOC_OFF_MASK      12'h01f
`define PIOC_OFF_CTRL      12'h020
`define PIOC_IDX_FLAGS     12'h006
`define PIOC_IDX_MASK      12'h007
`define PIOC_IDX_CTRL      12'h008
`define PIOC_BIT_ACL       0
`define PIOC_BIT_PHY       1
`define PIOC_BIT_SGMII     3
`define PIOC_INT_BITS      8'h0b
`define PIOC_MASK_RST      8'h00
`define PIOC_BIT_LLOOP     7
`define PIOC_BIT_RLOOP     6
`define PIOC_BIT_TTAG      2
`define PIOC_CTRL_BITS     8'hc7
`define PIOC_CTRL_RST      8'h00
`define PIOC_Q_ONE         2'h0
`define PIOC_Q_TWO         2'h1
`define PIOC_Q_FOUR        2'h2
`define PIOC_Q_RSVD        2'h3
`define PIOC_NPORTS        7
`endif

//--- src/pioc_port_regs.v
// One port's flags, mask and control registers with their side effects
`timescale 1ns/10ps
`include "pioc_defs.vh"
module pioc_port_regs #(
  parameter HAS_PHY = 1'b1
) (
  input  wire       clock_i,     // System clock
  input  wire       resetn_i,    // Async reset, active low
  input  wire       an_done_i,   // SGMII auto-negotiation done level
  input  wire       phy_irq_i,   // Summary of transceiver interrupts
  input  wire       acl_irq_i,   // ACL counter event pulse
  input  wire       mask_we_i,   // Write strobe for mask
  input  wire       ctrl_we_i,   // Write strobe for control
  input  wire [7:0] wdata_i,     // Write data
  output reg  [7:0] flags_o,     // Status register value
  output reg  [7:0] mask_o,      // Mask register value
  output reg  [7:0] ctrl_o,      // Control register value
  output reg        irq_o        // Port interrupt request
);
  reg  [7:0] flags_nxt;
  reg  [7:0] mask_nxt;
  wire       acl_toggle;

  assign acl_toggle = mask_we_i &
                      (wdata_i[`PIOC_BIT_ACL] != mask_o[`PIOC_BIT_ACL]);

  always @* begin
    mask_nxt = mask_o;
    if (mask_we_i) begin
      mask_nxt = wdata_i & `PIOC_INT_BITS;
      if (!HAS_PHY) begin
        mask_nxt[`PIOC_BIT_PHY] = 1'b0;
      end
    end
    flags_nxt = 8'h00;
    flags_nxt[`PIOC_BIT_SGMII] = an_done_i;
    flags_nxt[`PIOC_BIT_PHY] = HAS_PHY ? phy_irq_i : 1'b0;
    // ACL flag is sticky; a new event beats the clearing toggle
    flags_nxt[`PIOC_BIT_ACL] = acl_irq_i |
                               (flags_o[`PIOC_BIT_ACL] & ~acl_toggle);
  end

  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flags_o <= 8'h00;
      mask_o  <= `PIOC_MASK_RST;
      ctrl_o  <= `PIOC_CTRL_RST;
      irq_o   <= 1'b0;
    end else begin
      flags_o <= flags_nxt;
      mask_o  <= mask_nxt;
      if (ctrl_we_i) begin
        ctrl_o <= wdata_i & `PIOC_CTRL_BITS;
      end
      irq_o <= |(flags_nxt & ~mask_nxt & `PIOC_INT_BITS);
    end
  end
endmodule // pioc_port_regs

//--- dv/pioc_props.sv
// Checker for the port interrupt and control register bank
`timescale 1ns/10ps
module pioc_props #(
  parameter [6:0] PHY_PORTS = 7'h1f
) (
  input wire        clock_i, resetn_i, hsel_i, hwrite_i, hready_i,
  input wire [31:0] haddr_i, hwdata_i, hrdata_o,
  input wire [1:0]  htrans_i,
  input wire        hreadyout_o, hresp_o,
  input wire [6:0]  acl_irq_i, irq_o, local_loop_o, remote_loop_o,
  input wire [6:0]  tail_tag_o, prio_en_o,
  input wire [13:0] queue_mode_o
);
  reg        ap_v, ap_wr, wc_d, mask0_r;
  reg [15:0] ap_a;
  reg [7:0]  wd_r;
  reg [6:0]  prio_x;
  integer    k;
  wire rd_v = ap_v & ~ap_wr;
  wire is_c = ap_a[11:0] == 12'h020;
  wire wr_c = ap_v & ap_wr & is_c;
  wire wr_c1 = wr_c & (ap_a[15:12] == 4'h1);
  wire wr_m1 = ap_v & ap_wr & (ap_a == 16'h101f);
  wire mac_rd = rd_v & ~is_c & (ap_a[15:12] >= 4'h1) & (ap_a[15:12] <= 4'h7)
                & ~PHY_PORTS[ap_a[14:12] - 3'h1];
  always @* begin
    for (k = 0; k < 7; k = k + 1) prio_x[k] = ^queue_mode_o[2*k +: 2];
  end
  always @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      {ap_v, ap_wr, wc_d, mask0_r, ap_a, wd_r} <= 28'h0;
    end else begin
      ap_v <= hsel_i & hready_i & htrans_i[1];
      ap_wr <= hwrite_i;
      ap_a <= haddr_i[17:2];
      wc_d <= wr_c;
      if (wr_c1) wd_r <= hwdata_i[7:0];
      if (wr_m1) mask0_r <= hwdata_i[0];
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  chk_bus_okay: assert property (hreadyout_o && !hresp_o)
    else $error("bus not ready or not OKAY");
  chk_ctrl_outputs: assert property (wr_c1 |-> ##[1:2] {local_loop_o[0],
    remote_loop_o[0], tail_tag_o[0], queue_mode_o[1:0]} == {wd_r[7:6], wd_r[2:0]})
    else $error("control outputs differ from write");
  chk_ctrl_hold: assert property (!wr_c && !wc_d |=> $stable({local_loop_o,
    remote_loop_o, tail_tag_o, queue_mode_o})) else $error("control changed");
  chk_prio_map: assert property ($stable(queue_mode_o) |=> prio_en_o == prio_x)
    else $error("priority enable wrong");
  chk_rdata_idle: assert property (!rd_v |-> hrdata_o == 32'h0)
    else $error("read data outside read");
  chk_rsvd_zero: assert property (rd_v |->
    (hrdata_o & ~(is_c ? 32'hc7 : 32'h0b)) == 32'h0) else $error("reserved set");
  chk_mac_no_phy: assert property (mac_rd |-> !hrdata_o[1])
    else $error("phy bit on port without transceiver");
  chk_acl_raise: assert property (acl_irq_i[0] && !mask0_r && !wr_m1
    |-> ##[1:3] irq_o[0]) else $error("acl event gave no interrupt");
  cover property (wr_c1);
  cover property (rd_v && hrdata_o[0]);
  cover property ($rose(irq_o[0]));
endmodule // pioc_props

bind pioc_top pioc_props #(.PHY_PORTS(PHY_PORTS)) i_pioc_props (.clock_i,
  .resetn_i, .hsel_i, .hwrite_i, .hready_i, .haddr_i, .hwdata_i, .hrdata_o,
  .htrans_i, .hreadyout_o, .hresp_o, .acl_irq_i, .irq_o, .local_loop_o,
  .remote_loop_o, .tail_tag_o, .prio_en_o, .queue_mode_o);

//--- dv/port_irq_and_operation_control_tb.sv
// Self-checking bench for the port interrupt and control register bank
`timescale 1ns/10ps
`include "pioc_defs.vh"
module port_irq_and_operation_control_tb;
  reg         clock_i, resetn_i, hsel_i, hwrite_i;
  reg  [31:0] haddr_i, hwdata_i, rd_q, rv;
  reg  [1:0]  htrans_i;
  reg  [6:0]  an_done_i, phy_irq_i, acl_irq_i;
  wire [31:0] hrdata_o;
  wire        hreadyout_o, hresp_o;
  wire [6:0]  irq_o, local_loop_o, remote_loop_o, tail_tag_o, prio_en_o;
  wire [13:0] queue_mode_o;
  int         fail_count, total_checks, p;
  pioc_top i_pioc_top (.clock_i, .resetn_i, .hsel_i, .haddr_i, .htrans_i,
    .hwrite_i, .hsize_i(3'h2), .hwdata_i, .hready_i(hreadyout_o), .hrdata_o,
    .hreadyout_o, .hresp_o, .an_done_i, .phy_irq_i, .acl_irq_i, .irq_o,
    .local_loop_o, .remote_loop_o, .tail_tag_o, .queue_mode_o, .prio_en_o);
  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) rd_q <= hrdata_o;
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, seen);
      fail_count++;
    end
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    do begin @(posedge clock_i); n++; end while (hreadyout_o !== 1'b1 && n < 32);
    if (hreadyout_o !== 1'b1) begin fail_count++; tally_and_finish; end
  endtask
  // One single transfer; read data is the value captured at the last edge
  task automatic bus(input logic w, input int port, input logic [11:0] off,
                     input logic [7:0] d);
    @(posedge clock_i);
    hsel_i <= 1'b1; htrans_i <= 2'h2; hwrite_i <= w;
    haddr_i <= (port * `PIOC_PORT_STRIDE + off) << 2;
    wait_ready;
    hsel_i <= 1'b0; htrans_i <= 2'h0; hwdata_i <= {24'h0, d};
    wait_ready;
    @(negedge clock_i);
    rv = rd_q;
  endtask
  task automatic rdc(input string nm, input int port, input logic [11:0] off,
                     input logic [7:0] e);
    bus(1'b0, port, off, 8'h0);
    chk(nm, rv, {24'h0, e});
  endtask
  task automatic settle;
    repeat (3) @(posedge clock_i);
    @(negedge clock_i);
  endtask
  task automatic acl_pulse;
    @(posedge clock_i) acl_irq_i <= 7'h01;
    @(posedge clock_i) acl_irq_i <= 7'h00;
    settle;
  endtask
  initial begin
    {resetn_i, hsel_i, hwrite_i, haddr_i, hwdata_i, htrans_i} = '0;
    {an_done_i, phy_irq_i, acl_irq_i} = '0;
    fail_count = 0;
    total_checks = 0;
    repeat (16) @(posedge clock_i);
    resetn_i <= 1'b1;
    for (p = 1; p <= 7; p++) begin
      rdc("flags", p, `PIOC_OFF_FLAGS, 8'h00);
      rdc("mask", p, `PIOC_OFF_MASK, 8'h00);
      rdc("ctrl", p, `PIOC_OFF_CTRL, 8'h00);
    end
    for (p = 1; p <= 7; p++) begin
      bus(1'b1, p, `PIOC_OFF_CTRL, {p[0], p[1], 3'h7, p == 3, p[1:0]});
      rdc("ctrl", p, `PIOC_OFF_CTRL, {p[0], p[1], 3'h0, p == 3, p[1:0]});
      chk("loops", {local_loop_o[p-1], remote_loop_o[p-1], tail_tag_o[p-1]},
          {p[0], p[1], p == 3});
      chk("queue", queue_mode_o[2*p-2 +: 2], p[1:0]);
      chk("prio", prio_en_o[p-1], p[1:0] == 2'h1 || p[1:0] == 2'h2);
    end
    bus(1'b1, 1, `PIOC_OFF_FLAGS, 8'hff);
    rdc("flags_ro", 1, `PIOC_OFF_FLAGS, 8'h00);
    bus(1'b1, 0, `PIOC_OFF_MASK, 8'hff);
    rdc("unmapped", 0, `PIOC_OFF_MASK, 8'h00);
    bus(1'b1, 6, `PIOC_OFF_MASK, 8'hff);
    rdc("mask_mac", 6, `PIOC_OFF_MASK, 8'h09);
    bus(1'b1, 1, `PIOC_OFF_MASK, 8'hff);
    rdc("mask_phy", 1, `PIOC_OFF_MASK, 8'h0b);
    acl_pulse;
    rdc("acl_set", 1, `PIOC_OFF_FLAGS, 8'h01);
    rdc("acl_kept", 1, `PIOC_OFF_FLAGS, 8'h01);
    chk("irq_masked", irq_o, 7'h00);
    bus(1'b1, 1, `PIOC_OFF_MASK, 8'h0a);
    rdc("acl_clr", 1, `PIOC_OFF_FLAGS, 8'h00);
    acl_pulse;
    chk("irq_acl", irq_o, 7'h01);
    bus(1'b1, 1, `PIOC_OFF_MASK, 8'h0b);
    settle;
    chk("irq_clr", irq_o, 7'h00);
    @(posedge clock_i) {an_done_i, phy_irq_i} <= {7'h01, 7'h21};
    repeat (8) @(posedge clock_i);
    rdc("flags_phy", 1, `PIOC_OFF_FLAGS, 8'h0a);
    rdc("flags_mac", 6, `PIOC_OFF_FLAGS, 8'h00);
    bus(1'b1, 6, `PIOC_OFF_MASK, 8'h00);
    bus(1'b1, 1, `PIOC_OFF_MASK, 8'h09);
    settle;
    chk("irq_phy", irq_o, 7'h01);
    bus(1'b1, 1, `PIOC_OFF_MASK, 8'h03);
    settle;
    chk("irq_an", irq_o, 7'h01);
    @(posedge clock_i) an_done_i <= 7'h00;
    repeat (8) @(posedge clock_i);
    rdc("flags_an", 1, `PIOC_OFF_FLAGS, 8'h02);
    chk("irq_none", irq_o, 7'h00);
    tally_and_finish;
  end
endmodule // port_irq_and_operation_control_tb
